// >>> core/usart_pkg.sv
/*
 * Constants, field layouts and carrier types shared by the serial port
 * transmit/mode control block.
 * Assumes an 8-bit register port and one system clock at 10 MHz.
 */
package usart_pkg;

   // ***********************************************
   // sizes and address map
   // ***********************************************
   localparam int NUM_PORTS = 2;
   localparam int ADDR_W = 6;
   localparam int INST_BIT = 5;
   localparam logic [4:0] RX_CTRL_OFS = 5'h13;
   localparam logic [4:0] TX_CTRL_OFS = 5'h15;
   localparam logic [4:0] TX_DATA_OFS = 5'h16;
   localparam logic [4:0] BAUD_OFS = 5'h17;
   localparam logic [4:0] IRQ_STAT_OFS = 5'h18;
   localparam logic [4:0] IRQ_MASK_OFS = 5'h19;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int CLK_SRC_BIT = 7;
   localparam int NINE_BIT_BIT = 6;
   localparam int TX_EN_BIT = 5;
   localparam int SYNC_BIT = 4;
   localparam int SHIFT_EMPTY_BIT = 1;
   localparam int NINTH_BIT = 0;
   localparam int PORT_EN_BIT = 7;
   localparam int RX_NINE_BIT = 6;
   localparam int SINGLE_RX_BIT = 5;
   localparam int CONT_RX_BIT = 4;
   localparam int IRQ_BUF_EMPTY = 0;
   localparam int IRQ_TX_DONE = 1;
   localparam int IRQ_W = 2;

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic [7:0] TX_CTRL_RST = 8'h02;
   localparam logic [7:0] RX_CTRL_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // ***********************************************
   // timing: baud = Fosc/(64(X+1)) async, Fosc/(4(X+1)) sync
   // ***********************************************
   localparam int FOSC_PER_CYCLE = 4;
   localparam int ASYNC_FOSC_DIV = 64;
   localparam int SYNC_FOSC_DIV = 4;
   localparam int ASYNC_TICKS = ASYNC_FOSC_DIV / FOSC_PER_CYCLE;
   localparam int SYNC_TICKS = SYNC_FOSC_DIV / FOSC_PER_CYCLE;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;

   // ***********************************************
   // types
   // ***********************************************
   typedef struct packed {
      logic dataOut;
      logic dataOe;
      logic clkOut;
      logic clkOe;
   } pin_out_t;

   typedef enum logic [1:0] {IDLE, START, SHIFT, STOP} tx_state_t;

endpackage : usart_pkg

// >>> core/usart_tx_ctrl.sv
/*
 * Two independent serial port instances: mode/transmit control register,
 * receive control bits that steer pins, baud timer, transmit shifter,
 * pin direction control and a sticky interrupt per instance.
 * Assumes a single-cycle register port with read data one cycle later,
 * and pins resolved outside from out/enable pairs.
 */
`timescale 1ns/1ns

// Function
// - two independent port instances with identical control bits, each with own registers, irq and pins.
// - each port runs asynchronous full duplex, synchronous master or synchronous slave.
// - control bit 4 selects synchronous when 1, asynchronous when 0.
// - bit 7 in sync mode selects master with internal baud clock or slave with external clock.
// - bit 6 selects nine-bit characters when 1, eight-bit when 0.
// - bit 5 enables the transmitter.
// - in sync mode either receive enable overrides the transmit enable.
// - bits 3 and 2 always read zero.
// - bit 1 is read-only and is 1 while the shift register is empty.
// - bit 0 holds the ninth transmitted bit, written by software.
// - the port itself drives pin directions from its enable and clock source bits.
// - port enable gives the pins to the port; clear disables the port.
// - bit rate is Fosc/(64(X+1)) async and Fosc/(4(X+1)) sync master.
module usart_tx_ctrl
   import usart_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic clkPinIn [NUM_PORTS],
   output pin_out_t pinOut [NUM_PORTS],
   output logic irq [NUM_PORTS]
);

   logic [7:0] portRd [NUM_PORTS];

   // ***********************************************
   // register read port
   // ***********************************************
   // reads have no side effect; data stands one cycle and is zero otherwise
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         regRdata <= portRd[regAddr[INST_BIT]];
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ***********************************************
   // per-port logic
   // ***********************************************
   for (genvar i = 0; i < NUM_PORTS; i++) begin : port_g
      logic sel;
      logic [4:0] ofs;
      logic [7:0] txCtrl;
      logic [7:0] rxCtrl;
      logic [7:0] divisor;
      logic [7:0] txBuf;
      logic bufFull;
      logic [7:0] baudCnt;
      logic [3:0] subCnt;
      logic [2:0] clkSync;
      logic clkLevel;
      logic clkLast;
      tx_state_t state;
      logic [8:0] shiftReg;
      logic [3:0] bitsLeft;
      logic txLine;
      logic clkOut;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqMask;
      logic serial_port_enable, syncMode, master, txAct, run;
      logic baudTick, asyncTick, slaveFall, bitTick;
      logic loadEv, doneEv, shiftEmpty;
      logic rxClaim, bitLaunch;
      logic [IRQ_W-1:0] irqEv;
      logic wrTxCtrl, wrRxCtrl, wrBaud, wrData, wrStat, wrMask;

      assign sel = (regAddr[INST_BIT] == 1'(i));
      assign ofs = regAddr[4:0];
      assign wrTxCtrl = regWr && sel && (ofs == TX_CTRL_OFS);
      assign wrRxCtrl = regWr && sel && (ofs == RX_CTRL_OFS);
      assign wrBaud = regWr && sel && (ofs == BAUD_OFS);
      assign wrData = regWr && sel && (ofs == TX_DATA_OFS);
      assign wrStat = regWr && sel && (ofs == IRQ_STAT_OFS);
      assign wrMask = regWr && sel && (ofs == IRQ_MASK_OFS);

      // mode decode
      assign serial_port_enable = rxCtrl[PORT_EN_BIT];
      assign syncMode = txCtrl[SYNC_BIT];
      assign master = syncMode && txCtrl[CLK_SRC_BIT];
      // half duplex: a receive request in sync mode wins the line; in async
      // the receiver runs beside the transmitter, so it claims nothing
      assign rxClaim = syncMode && (rxCtrl[SINGLE_RX_BIT] || rxCtrl[CONT_RX_BIT]);
      assign txAct = txCtrl[TX_EN_BIT] && !rxClaim;
      assign run = serial_port_enable && txAct;

      // ***********************************************
      // control registers
      // ***********************************************
      // bits 3..1 are not stored; bit 1 is rebuilt from the shifter
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            txCtrl <= TX_CTRL_RST & 8'hF1;
         end else if (wrTxCtrl) begin
            txCtrl <= regWdata & 8'hF1;
         end
      end

      // only bits 7..4 live here, the pin-steering bits and nine-bit receive; receive status reads zero
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            rxCtrl <= RX_CTRL_RST;
         end else if (wrRxCtrl) begin
            rxCtrl <= regWdata & 8'hF0;
         end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            divisor <= BAUD_RST;
         end else if (wrBaud) begin
            divisor <= regWdata;
         end
      end

      // a write while a load happens keeps the buffer full
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            txBuf <= 8'h00;
            bufFull <= 1'b0;
         end else if (wrData) begin
            txBuf <= regWdata;
            bufFull <= 1'b1;
         end else if (loadEv) begin
            bufFull <= 1'b0;
         end
      end

      // ***********************************************
      // baud timer
      // ***********************************************
      // a divisor write restarts the timer so the new rate applies at once
      // the divisor is eight bits wide, so the slowest async bit is 4096 cycles
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            baudCnt <= 8'h00;
            subCnt <= 4'h0;
         end else if (wrBaud) begin
            baudCnt <= regWdata;
            subCnt <= 4'h0;
         end else if (baudCnt == 8'h00) begin
            baudCnt <= divisor;
            subCnt <= subCnt + 4'h1;
         end else begin
            baudCnt <= baudCnt - 8'h01;
         end
      end

      assign baudTick = (baudCnt == 8'h00);
      assign asyncTick = baudTick && (subCnt == 4'(ASYNC_TICKS - 1));

      // ***********************************************
      // slave clock input
      // ***********************************************
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            clkSync <= 3'h7;
         end else begin
            clkSync <= {clkSync[1:0], clkPinIn[i]};
         end
      end

      // a level is accepted only when the last two stages agree
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            clkLevel <= 1'b1;
            clkLast <= 1'b1;
         end else begin
            clkLast <= clkLevel;
            if (clkSync[1] == clkSync[2]) begin
               clkLevel <= clkSync[2];
            end
         end
      end

      assign slaveFall = clkLast && !clkLevel;
      // SYNC_TICKS is one: sync master shifts on every baud tick
      assign bitTick = !syncMode ? asyncTick :
                       master ? (baudTick && (SYNC_TICKS == 1)) : slaveFall;

      // ***********************************************
      // transmit shifter
      // ***********************************************
      assign loadEv = run && (state == IDLE) && bufFull;
      assign doneEv = run && bitTick &&
                      ((state == STOP) || (state == SHIFT && bitsLeft == 4'h0 && syncMode));
      assign shiftEmpty = (state == IDLE);

      // async frame: start, data LSB first, stop; sync sends data only
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            state <= IDLE;
            shiftReg <= 9'h000;
            bitsLeft <= 4'h0;
            txLine <= 1'b1;
         end else if (!run) begin
            state <= IDLE;
            txLine <= 1'b1;
         end else begin
            unique case (state)
               IDLE: begin
                  if (bufFull) begin
                     shiftReg <= {txCtrl[NINTH_BIT], txBuf};
                     bitsLeft <= txCtrl[NINE_BIT_BIT] ? BITS_NINE : BITS_EIGHT;
                     state <= START;
                  end
               end
               START: begin
                  if (bitTick) begin
                     state <= SHIFT;
                     if (syncMode) begin
                        txLine <= shiftReg[0];
                        shiftReg <= {1'b0, shiftReg[8:1]};
                        bitsLeft <= bitsLeft - 4'h1;
                     end else begin
                        txLine <= 1'b0;
                     end
                  end
               end
               SHIFT: begin
                  if (bitTick) begin
                     if (bitsLeft != 4'h0) begin
                        txLine <= shiftReg[0];
                        shiftReg <= {1'b0, shiftReg[8:1]};
                        bitsLeft <= bitsLeft - 4'h1;
                     end else if (syncMode) begin
                        state <= IDLE;
                     end else begin
                        txLine <= 1'b1;
                        state <= STOP;
                     end
                  end
               end
               STOP: begin
                  if (bitTick) begin
                     state <= IDLE;
                  end
               end
            endcase
         end
      end

      // a bit is launched on the tick that leaves START or shifts a data bit;
      // the tick that ends the frame launches none, so it gives no clock pulse
      // and a slave counts exactly one rising edge per bit
      assign bitLaunch = bitTick && ((state == START) || (state == SHIFT && bitsLeft != 4'h0));

      // master clock is low for the first cycle of each bit; with a zero
      // divisor the bit is one cycle long and the clock cannot rise
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            clkOut <= 1'b1;
         end else begin
            clkOut <= !(run && master && bitLaunch);
         end
      end

      // ***********************************************
      // pin direction
      // ***********************************************
      // enables follow the mode bits one cycle late; the pad resolves level and enable outside
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            pinOut[i] <= '{dataOut: 1'b1, dataOe: 1'b0, clkOut: 1'b1, clkOe: 1'b0};
         end else if (!syncMode) begin
            // async: transmit on the clock pin, data pin is receive input
            pinOut[i] <= '{dataOut: 1'b1, dataOe: 1'b0, clkOut: txLine, clkOe: serial_port_enable};
         end else begin
            pinOut[i] <= '{dataOut: txLine, dataOe: run,
                           clkOut: clkOut, clkOe: serial_port_enable && master};
         end
      end

      // ***********************************************
      // interrupts
      // ***********************************************
      // event positions follow the status layout, not the order of the signals
      always_comb begin
         irqEv = IRQ_RST;
         irqEv[IRQ_BUF_EMPTY] = loadEv;
         irqEv[IRQ_TX_DONE] = doneEv;
      end

      // a hardware event in the clearing cycle survives the clear
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            irqStat <= IRQ_RST;
         end else begin
            irqStat <= (irqStat & ~(wrStat ? regWdata[IRQ_W-1:0] : IRQ_RST)) |
                       irqEv;
         end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            irqMask <= IRQ_RST;
         end else if (wrMask) begin
            irqMask <= regWdata[IRQ_W-1:0];
         end
      end

      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            irq[i] <= 1'b0;
         end else begin
            irq[i] <= |(irqStat & irqMask);
         end
      end

      // ***********************************************
      // read mux
      // ***********************************************
      always_comb begin
         unique case (ofs)
            TX_CTRL_OFS: portRd[i] = {txCtrl[7:4], 2'b00, shiftEmpty, txCtrl[NINTH_BIT]};
            RX_CTRL_OFS: portRd[i] = rxCtrl;
            BAUD_OFS: portRd[i] = divisor;
            TX_DATA_OFS: portRd[i] = 8'h00; // write-only buffer
            IRQ_STAT_OFS: portRd[i] = {6'h00, irqStat};
            IRQ_MASK_OFS: portRd[i] = {6'h00, irqMask};
            default: portRd[i] = 8'h00;
         endcase
      end
   end

endmodule : usart_tx_ctrl

// >>> verification/usart_peer.sv
/* serial peer: async listener at sixteen cycles a bit, sync bit catcher
   and slave clock source.
   assumes the bench resolves the pin levels it is given */
`timescale 1ns/1ns
module usart_peer (
   input wire logic sys_clk,
   input wire logic line,
   input wire logic dat,
   input wire logic listen,
   input wire logic nine,
   input wire logic slaveRun,
   output logic slaveClk,
   output logic [8:0] word,
   output logic [8:0] syncSh,
   output int count
);
   logic [8:0] sh;
   // the slave clock stands still high while slaveRun is low
   initial begin
      slaveClk = 1'b1;
      forever begin
         repeat (8) @(posedge sys_clk);
         slaveClk <= slaveRun ? ~slaveClk : 1'b1;
      end
   end
   always @(posedge line) if (!listen) syncSh <= {dat, syncSh[8:1]};
   initial begin
      count = 0;
      word = 9'h000;
      forever begin
         @(negedge line iff listen);
         sh = 9'h000;
         repeat (8) @(posedge sys_clk);
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (16) @(posedge sys_clk);
            sh[i] = line;
         end
         repeat (16) @(posedge sys_clk);
         // a missing stop bit is simply not counted
         if (line) word = sh;
         if (line) count++;
      end
   end
endmodule : usart_peer

// >>> verification/usart_transmit_mode_control_tb.sv
/* self-checking bench for the serial port control block.
   assumes usart_tx_ctrl, the peer model and the bound checker are compiled first */
`timescale 1ns/1ns
module usart_transmit_mode_control_tb;
   import usart_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [7:0] regWdata = '0, regRdata, v;
   logic clkPinIn [NUM_PORTS];
   pin_out_t pinOut [NUM_PORTS];
   logic irq [NUM_PORTS];
   logic listen = 1'b0, nine = 1'b0, slaveRun = 1'b0, slaveClk, clkWire, dat;
   logic [8:0] word, syncSh;
   int count, c, n_errors = 0, check_count = 0, cycles = 0, seed = 29;
   // a released data pin shows a changing pattern, not its last value
   assign clkWire = pinOut[0].clkOe ? pinOut[0].clkOut : slaveClk;
   assign dat = pinOut[0].dataOe ? pinOut[0].dataOut : cycles[0];
   assign clkPinIn[0] = clkWire;
   assign clkPinIn[1] = pinOut[1].clkOe ? pinOut[1].clkOut : 1'b1;
   usart_tx_ctrl dut (.sys_clk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .clkPinIn, .pinOut, .irq);
   usart_peer peer (.sys_clk, .line(clkWire), .dat, .listen, .nine, .slaveRun, .slaveClk, .word, .syncSh, .count);
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end
   function automatic logic [7:0] ctlExp(input logic [7:0] w);
      return (w & 8'hF1) | 8'h02;
   endfunction : ctlExp
   function automatic logic [8:0] wordExp(input logic n, input logic b, input logic [7:0] d);
      return n ? {b, d} : {1'b0, d};
   endfunction : wordExp
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // every bus task starts and ends just after a clock edge
   task automatic wr(input logic [5:0] a, input logic [7:0] w);
      regAddr <= a;
      regWdata <= w;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : wr
   task automatic rdChk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 check({1'b0, regRdata & m}, {1'b0, e});
      @(posedge sys_clk);
      #1;
   endtask : rdChk
   task automatic waitRx(input int n);
      for (int i = 0; i < 400 && count < n; i++) @(posedge sys_clk);
      check(9'(count >= n), 9'h001);
      repeat (16) @(posedge sys_clk);
      #1;
   endtask : waitRx
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 2; i++) begin
         rdChk({i[0], TX_CTRL_OFS}, 8'hFF, TX_CTRL_RST);
         rdChk({i[0], RX_CTRL_OFS}, 8'hFF, 8'h00);
         rdChk({i[0], 5'h1F}, 8'hFF, 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hFF : 8'($random(seed));
         wr({1'b1, TX_CTRL_OFS}, v);
         rdChk({1'b1, TX_CTRL_OFS}, 8'hFF, ctlExp(v));
      end
      wr({1'b1, TX_CTRL_OFS}, 8'h00);
      wr({1'b0, IRQ_MASK_OFS}, 8'h02);
      wr({1'b0, RX_CTRL_OFS}, 8'h80);
      listen <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         nine <= i[0];
         v = 8'($random(seed));
         c = count;
         wr({1'b0, TX_CTRL_OFS}, 8'h20 | {1'b0, i[0], 5'h00, i[1]});
         wr({1'b0, TX_DATA_OFS}, v);
         rdChk({1'b0, TX_CTRL_OFS}, 8'h02, 8'h00);
         waitRx(c + 1);
         check(word, wordExp(i[0], i[1], v));
         rdChk({1'b0, TX_CTRL_OFS}, 8'h02, 8'h02);
         check(9'({irq[0], irq[1]}), 9'h002);
         wr({1'b0, IRQ_STAT_OFS}, 8'h03);
         check(9'(irq[0]), 9'h000);
      end
      nine <= 1'b0;
      wr({1'b0, TX_CTRL_OFS}, 8'h20);
      c = count;
      wr({1'b0, TX_DATA_OFS}, 8'hA5);
      wr({1'b0, TX_DATA_OFS}, 8'h3C);
      waitRx(c + 1);
      check(word, 9'h0A5);
      waitRx(c + 2);
      check(word, 9'h03C);
      wr({1'b0, TX_DATA_OFS}, 8'h00);
      repeat (40) @(posedge sys_clk);
      #1 check(9'(clkWire), 9'h000);
      wr({1'b0, TX_CTRL_OFS}, 8'h00);
      @(posedge sys_clk);
      #1 check(9'(clkWire), 9'h001);
      repeat (200) @(posedge sys_clk);
      listen <= 1'b0;
      wr({1'b0, BAUD_OFS}, 8'h03);
      wr({1'b0, TX_CTRL_OFS}, 8'hB0);
      v = 8'($random(seed));
      wr({1'b0, TX_DATA_OFS}, v);
      repeat (60) @(posedge sys_clk);
      #1 check({1'b0, syncSh[8:1]}, {1'b0, v});
      rdChk({1'b0, TX_CTRL_OFS}, 8'h02, 8'h02);
      for (int i = 0; i < 2; i++) begin
         wr({1'b0, RX_CTRL_OFS}, i[0] ? 8'hA0 : 8'h90);
         wr({1'b0, TX_DATA_OFS}, 8'($random(seed)));
         repeat (8) @(posedge sys_clk);
         #1 check(9'(pinOut[0].dataOe), 9'h000);
      end
      wr({1'b0, RX_CTRL_OFS}, 8'h80);
      repeat (4) @(posedge sys_clk);
      #1 check(9'(pinOut[0].dataOe), 9'h001);
      repeat (100) @(posedge sys_clk);
      wr({1'b0, TX_CTRL_OFS}, 8'h30);
      wr({1'b0, TX_DATA_OFS}, 8'($random(seed)));
      slaveRun <= 1'b1;
      repeat (40) @(posedge sys_clk);
      #1 check(9'({pinOut[0].clkOe, pinOut[0].dataOe}), 9'h001);
      repeat (200) @(posedge sys_clk);
      slaveRun <= 1'b0;
      rdChk({1'b0, TX_CTRL_OFS}, 8'h02, 8'h02);
      wr({1'b0, TX_CTRL_OFS}, 8'hB0);
      check(9'(pinOut[0].clkOe), 9'h001);
      wr({1'b0, RX_CTRL_OFS}, 8'h00);
      check(9'({pinOut[0].clkOe, pinOut[0].dataOe}), 9'h000);
      conclude();
   end
endmodule : usart_transmit_mode_control_tb

// >>> verification/usart_tx_ctrl_asserts.sv
/* checker for the serial port control block: pin direction, bit timing,
   read-back and interrupt gating of port 0, judged from the register writes it sees.
   assumes it is bound to usart_tx_ctrl and sees only that module's ports */
`timescale 1ns/1ns
module usart_tx_ctrl_asserts
   import usart_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic clkPinIn [NUM_PORTS],
   input wire pin_out_t pinOut [NUM_PORTS],
   input wire logic irq [NUM_PORTS]
);
   // ****************************
   // mirrors of port 0 registers
   // ****************************
   logic [7:0] txCtl, rxCtl, baud;
   logic [IRQ_W-1:0] mask;
   logic [1:0] quiet;
   logic sync, tOn, wr0;
   assign wr0 = regWr && !regAddr[INST_BIT];
   assign sync = txCtl[SYNC_BIT];
   assign tOn = rxCtl[PORT_EN_BIT] && txCtl[TX_EN_BIT];
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         txCtl <= TX_CTRL_RST;
         rxCtl <= RX_CTRL_RST;
         baud <= BAUD_RST;
         mask <= IRQ_RST;
      end else if (wr0) begin
         if (regAddr[4:0] == TX_CTRL_OFS) txCtl <= regWdata;
         if (regAddr[4:0] == RX_CTRL_OFS) rxCtl <= regWdata;
         if (regAddr[4:0] == BAUD_OFS) baud <= regWdata;
         if (regAddr[4:0] == IRQ_MASK_OFS) mask <= regWdata[IRQ_W-1:0];
      end
   end
   // pins are registered, so checks wait until a write has settled
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) quiet <= 2'h0;
      else if (wr0) quiet <= 2'h0;
      else if (quiet != 2'h3) quiet <= quiet + 2'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_hold;
      $stable(pinOut[0].clkOut) || !tOn;
   endsequence
   property p_resv;
      regRd && regAddr[4:0] == TX_CTRL_OFS |=> regRdata[3:2] == 2'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("unused control bits read nonzero");
   property p_busy;
      regRd && regAddr == {1'b0, TX_CTRL_OFS} && tOn && !sync && pinOut[0].clkOe && !pinOut[0].clkOut
         |=> !regRdata[SHIFT_EMPTY_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("shifter shown empty while a bit is on the line");
   property p_async;
      quiet == 2'h3 && !sync |-> pinOut[0].clkOe == rxCtl[PORT_EN_BIT] && !pinOut[0].dataOe;
   endproperty
   a_async: assert property (p_async) else $error("async pin direction wrong");
   property p_off;
      quiet == 2'h3 && !rxCtl[PORT_EN_BIT] |-> !pinOut[0].clkOe && !pinOut[0].dataOe;
   endproperty
   a_off: assert property (p_off) else $error("disabled port drives a pin");
   property p_clkSrc;
      quiet == 2'h3 && sync |-> pinOut[0].clkOe == (rxCtl[PORT_EN_BIT] && txCtl[CLK_SRC_BIT]);
   endproperty
   a_clkSrc: assert property (p_clkSrc) else $error("clock pin direction wrong in sync mode");
   property p_rxWins;
      quiet == 2'h3 && sync && (rxCtl[SINGLE_RX_BIT] || rxCtl[CONT_RX_BIT]) |-> !pinOut[0].dataOe;
   endproperty
   a_rxWins: assert property (p_rxWins) else $error("data pin driven while receive enabled");
   property p_bitLen;
      $changed(pinOut[0].clkOut) && quiet == 2'h3 && !sync && tOn && baud == 8'h00 |=> s_hold[*8] ##1 s_hold[*7];
   endproperty
   a_bitLen: assert property (p_bitLen) else $error("async bit shorter than sixteen cycles");
   property p_irqOff;
      quiet == 2'h3 && mask == '0 |-> !irq[0];
   endproperty
   a_irqOff: assert property (p_irqOff) else $error("masked interrupt raised");
endmodule : usart_tx_ctrl_asserts

bind usart_tx_ctrl usart_tx_ctrl_asserts chk (.sys_clk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
   .clkPinIn, .pinOut, .irq);
